// File: inc/irtp_pkg.sv
// package for the internal ram test data port
// assumes a 32-bit register port and a ram side that answers each request with ack
package irtp_pkg;

    // ========================================
    // register offsets
    localparam logic [7:0] OFF_SEL = 8'h40;
    localparam logic [7:0] OFF_CMD = 8'h44;
    localparam logic [7:0] OFF_ADDR = 8'h48;
    localparam logic [7:0] OFF_DATA_LO = 8'h4C;
    localparam logic [7:0] OFF_DATA_HI = 8'h50;

    // ========================================
    // field layout
    localparam int READY_BIT = 31;
    localparam int TEST_EN_BIT = 0;
    localparam int SEL_LSB = 1;
    localparam int SEL_W = 2;
    localparam int CMD_WR_BIT = 0;
    localparam int ADDR_W = 15;
    localparam int HI_W = 5;
    localparam int RAM_W = 37;

    // ========================================
    // reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [31:0] DATA_LO_RST = 32'h0000_0000;
    localparam logic [HI_W-1:0] DATA_HI_RST = 5'h00;

    // ========================================
    // ram targets
    typedef enum logic [SEL_W-1:0] {
        RAM_FIRST_DATA = 2'h0,
        RAM_EEPROM_STORE = 2'h1,
        RAM_TX_LINK = 2'h2,
        RAM_RX_LINK = 2'h3
    } irtp_ram_sel_t;

    // request to the selected ram
    typedef struct packed {
        logic req;
        logic wr;
        irtp_ram_sel_t sel;
        logic [ADDR_W-1:0] addr;
        logic [RAM_W-1:0] wdata;
    } irtp_ram_req_t;

    // answer from the selected ram
    typedef struct packed {
        logic ack;
        logic [RAM_W-1:0] rdata;
    } irtp_ram_rsp_t;

endpackage : irtp_pkg

// File: hw/irtp_reg.sv
// one resettable register field with a write strobe
// assumes core_clk domain, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module irtp_reg #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // load
    input wire logic we,
    input wire logic [W-1:0] d,
    // value
    output logic [W-1:0] q
);
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= RST;
        end else if (we) begin
            q <= d;
        end
    end
endmodule // irtp_reg
`default_nettype wire

// File: hw/irtp_top.sv
// internal ram test data port: register bank and access sequencer
// assumes software keeps the port to test use; ram answers with ack
//
// Functional notes
// RULE1: software sets test enable before access
// RULE2: port used only for test, not runtime
// RULE3: select field bits 2:1 picks ram
// RULE4: ready bit 31 low busy, resets high
// RULE5: read raises ready after data stored
// RULE6: a command write while idle starts one access; a command write while busy is ignored
// RULE7: software loads address and data first
// RULE8: 15-bit word address in bits 14:0
// RULE9: low data word gives write, takes read
// RULE10: software checks ready before taking result
// RULE11: high data bits 4:0 carry bits 36:32
// RULE12: test enable puts all rams in test
// RULE13: ready drops next cycle, stays until done
`timescale 1ns/1ps
`default_nettype none
module irtp_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // ram side
    output irtp_pkg::irtp_ram_req_t ram_req,
    input wire irtp_pkg::irtp_ram_rsp_t ram_rsp,
    output logic ram_test_enable
);

    // ========================================
    // state
    typedef enum logic {
        ST_IDLE,
        ST_BUSY
    } irtp_state_t;

    irtp_state_t state_q;
    logic port_ready_flag_q;
    logic [irtp_pkg::SEL_W-1:0] ram_select_q;
    logic cmd_wr_q;
    logic [irtp_pkg::ADDR_W-1:0] addr_q;
    logic [31:0] data_lo_q;
    logic [irtp_pkg::HI_W-1:0] data_hi_q;
    logic [31:0] rdata_d;
    logic we_sel;
    logic we_cmd;
    logic we_addr;
    logic we_lo;
    logic we_hi;
    logic start;
    logic done;
    logic load_rd;
    logic [31:0] lo_d;
    logic [irtp_pkg::HI_W-1:0] hi_d;

    // ========================================
    // write decode
    assign we_sel = reg_wr && (reg_addr == irtp_pkg::OFF_SEL);
    assign we_cmd = reg_wr && (reg_addr == irtp_pkg::OFF_CMD);
    assign we_addr = reg_wr && (reg_addr == irtp_pkg::OFF_ADDR);
    assign we_lo = reg_wr && (reg_addr == irtp_pkg::OFF_DATA_LO);
    assign we_hi = reg_wr && (reg_addr == irtp_pkg::OFF_DATA_HI);
    // a command write while busy is ignored
    assign start = we_cmd && (state_q == ST_IDLE); // RULE6
    assign done = (state_q == ST_BUSY) && ram_rsp.ack;
    assign load_rd = done && !cmd_wr_q;

    // ========================================
    // select register fields
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ram_test_enable <= 1'b0;
            ram_select_q <= irtp_pkg::RAM_FIRST_DATA;
        end else if (we_sel) begin
            ram_test_enable <= reg_wdata[irtp_pkg::TEST_EN_BIT]; // RULE12
            ram_select_q <= reg_wdata[irtp_pkg::SEL_LSB +: irtp_pkg::SEL_W];
        end
    end

    // ========================================
    // command and address registers
    irtp_reg #(.W(1), .RST(1'b0)) u_cmd (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .we(start),
        .d(reg_wdata[irtp_pkg::CMD_WR_BIT]),
        .q(cmd_wr_q)
    );

    irtp_reg #(.W(irtp_pkg::ADDR_W), .RST(irtp_pkg::ADDR_RST)) u_addr (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .we(we_addr),
        .d(reg_wdata[irtp_pkg::ADDR_W-1:0]), // RULE8
        .q(addr_q)
    );

    // ========================================
    // data registers, loaded by software or by a read result
    assign lo_d = load_rd ? ram_rsp.rdata[31:0] : reg_wdata; // RULE9
    assign hi_d = load_rd ? ram_rsp.rdata[irtp_pkg::RAM_W-1:32]
                          : reg_wdata[irtp_pkg::HI_W-1:0]; // RULE11

    irtp_reg #(.W(32), .RST(irtp_pkg::DATA_LO_RST)) u_lo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .we(we_lo || load_rd),
        .d(lo_d),
        .q(data_lo_q)
    );

    irtp_reg #(.W(irtp_pkg::HI_W), .RST(irtp_pkg::DATA_HI_RST)) u_hi (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .we(we_hi || load_rd),
        .d(hi_d),
        .q(data_hi_q)
    );

    // ========================================
    // access sequencer
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    if (ram_rsp.ack) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ready falls after start, rises with read data already stored
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            port_ready_flag_q <= 1'b1; // RULE4
        end else if (start) begin
            port_ready_flag_q <= 1'b0; // RULE13
        end else if (done) begin
            port_ready_flag_q <= 1'b1; // RULE5
        end
    end

    // ========================================
    // ram request, registered
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ram_req <= '0;
        end else if (start) begin
            ram_req.req <= 1'b1;
            ram_req.wr <= reg_wdata[irtp_pkg::CMD_WR_BIT]; // RULE6
            ram_req.sel <= irtp_pkg::irtp_ram_sel_t'(ram_select_q); // RULE3
            ram_req.addr <= addr_q;
            ram_req.wdata <= {data_hi_q, data_lo_q}; // RULE11
        end else if (done) begin
            ram_req.req <= 1'b0;
        end
    end

    // ========================================
    // read mux
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (reg_addr)
            irtp_pkg::OFF_SEL: begin
                rdata_d[irtp_pkg::READY_BIT] = port_ready_flag_q; // RULE4
                rdata_d[irtp_pkg::SEL_LSB +: irtp_pkg::SEL_W] = ram_select_q;
                rdata_d[irtp_pkg::TEST_EN_BIT] = ram_test_enable;
            end
            irtp_pkg::OFF_CMD: begin
                rdata_d[irtp_pkg::CMD_WR_BIT] = cmd_wr_q;
            end
            irtp_pkg::OFF_ADDR: begin
                rdata_d[irtp_pkg::ADDR_W-1:0] = addr_q;
            end
            irtp_pkg::OFF_DATA_LO: begin
                rdata_d = data_lo_q;
            end
            irtp_pkg::OFF_DATA_HI: begin
                rdata_d[irtp_pkg::HI_W-1:0] = data_hi_q;
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule // irtp_top
`default_nettype wire

// File: tb/irtp_top_properties.sv
// checker for the ram test data port
// assumes it is bound to irtp_top
`timescale 1ns/1ps
`default_nettype none
module irtp_top_properties (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // ram side
    input wire irtp_pkg::irtp_ram_req_t ram_req,
    input wire irtp_pkg::irtp_ram_rsp_t ram_rsp,
    input wire logic ram_test_enable
);
    // ==================
    // properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    chk_cmd_start: assert property (
        reg_wr && reg_addr == irtp_pkg::OFF_CMD && !ram_req.req
        |=> ram_req.req && ram_req.wr == $past(reg_wdata[0]))
        else $error("command gave no access");
    chk_req_hold: assert property (
        ram_req.req && !ram_rsp.ack |=> $stable(ram_req))
        else $error("request changed before ack");
    chk_ack_ends: assert property (
        ram_req.req && ram_rsp.ack |=> !ram_req.req)
        else $error("request stayed after ack");
    chk_ready_read: assert property (
        reg_rd && reg_addr == irtp_pkg::OFF_SEL
        |=> reg_rdata[31] == !$past(ram_req.req))
        else $error("ready flag wrong");
    chk_read_result: assert property (
        ram_req.req && !ram_req.wr && ram_rsp.ack ##1
        reg_rd && reg_addr == irtp_pkg::OFF_DATA_LO
        |=> reg_rdata == $past(ram_rsp.rdata[31:0], 2))
        else $error("read result not stored");
    chk_test_bit: assert property (
        reg_rd && reg_addr == irtp_pkg::OFF_SEL
        |=> reg_rdata[0] == $past(ram_test_enable)
        && reg_rdata[30:3] == 28'h0)
        else $error("select register wrong");
    chk_addr_width: assert property (
        reg_rd && reg_addr == irtp_pkg::OFF_ADDR
        |=> reg_rdata[31:15] == 17'h0)
        else $error("address register too wide");
    chk_high_width: assert property (
        reg_rd && reg_addr == irtp_pkg::OFF_DATA_HI
        |=> reg_rdata[31:5] == 27'h0)
        else $error("high data register too wide");
endmodule // irtp_top_properties
bind irtp_top irtp_top_properties u_chk (.core_clk, .rst_b, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ram_req, .ram_rsp,
    .ram_test_enable);
`default_nettype wire

// File: tb/irtp_top_bench.sv
// bench for the ram test data port
// assumes irtp_top, ram side answered by the bench
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %0t %h %h", $time, g, e); end end
module irtp_top_bench;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] a = 8'h00;
    logic [31:0] wd = 32'h0000_0000;
    logic w = 1'b0;
    logic r = 1'b0;
    logic [31:0] rq;
    logic te;
    irtp_pkg::irtp_ram_req_t q;
    irtp_pkg::irtp_ram_rsp_t s = '0;
    int mismatches = 0;
    int n_tests = 0;
    logic [36:0] d;
    logic [1:0] sv;
    always #20 core_clk = ~core_clk;
    irtp_top dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(a),
        .reg_wdata(wd), .reg_wr(w), .reg_rd(r), .reg_rdata(rq),
        .ram_req(q), .ram_rsp(s), .ram_test_enable(te));
    // ==================
    // tasks
    task wr(input logic [7:0] ad, input logic [31:0] v);
        a <= ad;
        wd <= v;
        w <= 1'b1;
        @(posedge core_clk);
        w <= 1'b0;
        @(posedge core_clk);
    endtask
    task rd(input logic [7:0] ad, input logic [31:0] e);
        a <= ad;
        r <= 1'b1;
        @(posedge core_clk);
        r <= 1'b0;
        @(negedge core_clk);
        `CHK(rq, e)
        @(posedge core_clk);
    endtask
    task ack(input logic [36:0] x);
        repeat (2) @(posedge core_clk);
        s <= {1'b1, x};
        @(posedge core_clk);
        s <= {1'b0, ~x};
    endtask
    task stop_test;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ==================
    // sequence
    initial begin
        #200000;
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        rd(irtp_pkg::OFF_SEL, 32'h8000_0000);
        for (int k = 1; k < 6; k++) rd(8'h40 + 8'h04 * k, 32'h0);
        for (int i = 0; i < 4; i++) begin
            sv = i[1:0];
            d = {3'h5, sv, 30'h2A5A_5A5A, sv};
            wr(irtp_pkg::OFF_SEL, {29'h0, sv, 1'b1});
            `CHK(te, 1'b1)
            rd(irtp_pkg::OFF_SEL, {29'h1000_0000, sv, 1'b1});
            wr(irtp_pkg::OFF_ADDR, {28'hFFF_FFFF, 2'b00, sv});
            rd(irtp_pkg::OFF_ADDR, {17'h0, 11'h7FF, 2'b00, sv});
            wr(irtp_pkg::OFF_DATA_LO, d[31:0]);
            wr(irtp_pkg::OFF_DATA_HI, {27'h7FF_FFFF, d[36:32]});
            rd(irtp_pkg::OFF_DATA_HI, {27'h0, d[36:32]});
            wr(irtp_pkg::OFF_CMD, 32'h1);
            rd(irtp_pkg::OFF_SEL, {29'h0, sv, 1'b1});
            wr(irtp_pkg::OFF_CMD, 32'h0);
            `CHK(q, {2'b11, sv, 11'h7FF, 2'b00, sv, d})
            ack(d);
            rd(irtp_pkg::OFF_SEL, {29'h1000_0000, sv, 1'b1});
            wr(irtp_pkg::OFF_CMD, 32'h0);
            `CHK({q.req, q.wr}, 2'b10)
            ack(~d);
            rd(irtp_pkg::OFF_DATA_LO, ~d[31:0]);
            rd(irtp_pkg::OFF_DATA_HI, {27'h0, ~d[36:32]});
        end
        wr(irtp_pkg::OFF_SEL, 32'h0);
        `CHK(te, 1'b0)
        stop_test();
    end
endmodule // irtp_top_bench
`default_nettype wire
